// [core/vmul_regs.svh]
`ifndef VMUL_REGS_SVH
`define VMUL_REGS_SVH

`define OP_MUL 8'h01
`define OP_MUL_IEEE 8'h02
`define OP_MUL_ADD 8'h14
`define OP_MUL_ADD_HALF 8'h17
`define OP_MUL64_SCALAR 8'h1b
`define OP_MUL_LIGHT 8'h1f
`define OP_UINT24 8'hb5
`define OP_MUL64_VECTOR 8'hca
`define OP_DEP_MUL 8'hd1
`define OP_DEP_MUL_IEEE 8'hd2

`define FLD_CTRL 3'h0
`define FLD_SRC0 3'h1
`define FLD_SRC1 3'h2
`define FLD_SRC2 3'h3
`define FLD_RESULT 3'h4
`define ADR_ISSUE 8'h80

`define CTRL_RESET 17'h00000
`define SRC_RESET 32'h00000000

`define SCALE_NONE 2'h0
`define SCALE_HALF 2'h3

`define CANON_NAN_DBL 64'h0fff800000000000
`define QNAN32 32'h7fc00000
`define QUIET32 32'h00400000
`define NEG_MAX_F32 32'hff7fffff
`define NEG_INF_F32 32'hff800000
`define ONE_F32 64'h000000003f800000
`define ONE_F64 64'h3ff0000000000000

`endif

// [core/vmul_pkg.sv]
package vmul_pkg;

   typedef struct packed {
      logic clamp;
      logic [1:0] output_scale_field;
      logic [2:0] src_abs;
      logic [2:0] src_neg;
      logic [7:0] alu_opcode_field;
   } slot_ctrl_t;

   typedef struct packed {
      logic [31:0] src2;
      logic [31:0] src1;
      logic [31:0] src0;
   } slot_src_t;

endpackage : vmul_pkg

// [core/vector_multiply_unit.sv]
`timescale 1ns/1ps
`include "vmul_regs.svh"

// Function
// - Double multiply of X/W pairs, low 64 bits
// - Denormals as zero, xor sign, canonical NaN
// - NaN operand propagates, first source wins
// - Double multiply decodes from opcodes 27, 202
// - Low word to slots 0,2; high to 1,3
// - Double source modifiers from slot 0 only
// - Double output modifiers from slot 0 only
// - IEEE multiply keeps IEEE zero semantics
// - Dependent multiply chains partner channel product
// - Forwarded product skips partner output modifiers
// - Dependent opcodes 209 legacy, 210 IEEE
// - Lighting multiply replicated, zero wins
// - Lighting multiply clamps to most negative float
// - Narrow unsigned product, low 32 bits
// - Multiply then add, two roundings
// - Halved multiply-add result
// - Plain multiply: zero operand gives zero
module vector_multiply_unit (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o
);

   ////////////////////////////////////////////////////////////////////////
   // Arithmetic. Rounding is toward zero and denormals flush to zero, which
   // keeps the datapath small at the cost of last-bit accuracy.

   function automatic logic [31:0] fmul32(input logic [31:0] a,
                                          input logic [31:0] b,
                                          input logic ieee);
      logic an, bn, ai, bi, az, bz, s;
      logic [47:0] p;
      logic [9:0] e;
      an = (&a[30:23]) && (|a[22:0]);
      bn = (&b[30:23]) && (|b[22:0]);
      ai = (&a[30:23]) && !(|a[22:0]);
      bi = (&b[30:23]) && !(|b[22:0]);
      az = a[30:23] == 8'h00;
      bz = b[30:23] == 8'h00;
      s = a[31] ^ b[31];
      p = {1'b1, a[22:0]} * {1'b1, b[22:0]};
      e = {2'b00, a[30:23]} + {2'b00, b[30:23]} - 10'd127 + {9'h000, p[47]};
      if (!ieee && (az || bz))
         fmul32 = 32'h00000000;
      else if (an)
         fmul32 = a | `QUIET32;
      else if (bn)
         fmul32 = b | `QUIET32;
      else if ((ai && bz) || (bi && az))
         fmul32 = `QNAN32;
      else if (ai || bi)
         fmul32 = {s, 8'hff, 23'h000000};
      else if (az || bz || e[9] || e == 10'h000)
         fmul32 = {s, 31'h00000000};
      else if (e >= 10'h0ff)
         fmul32 = {s, 8'hff, 23'h000000};
      else
         fmul32 = {s, e[7:0], p[47] ? p[46:24] : p[45:23]};
   endfunction : fmul32

   function automatic logic [31:0] fadd32(input logic [31:0] a,
                                          input logic [31:0] b);
      logic [31:0] x, y;
      logic [27:0] sm;
      logic [26:0] mx, my;
      logic [9:0] e;
      logic [7:0] d;
      x = (a[30:0] >= b[30:0]) ? a : b;
      y = (a[30:0] >= b[30:0]) ? b : a;
      mx = {1'b1, x[22:0], 3'b000};
      d = x[30:23] - y[30:23];
      my = (d > 8'd26) ? 27'h0 : ({1'b1, y[22:0], 3'b000} >> d);
      sm = (x[31] == y[31]) ? {1'b0, mx} + {1'b0, my}
                            : {1'b0, mx} - {1'b0, my};
      e = {2'b00, x[30:23]};
      if ((&a[30:23]) && (|a[22:0]))
         fadd32 = a | `QUIET32;
      else if ((&b[30:23]) && (|b[22:0]))
         fadd32 = b | `QUIET32;
      else if ((&x[30:23]) && (&y[30:23]) && (x[31] != y[31]))
         fadd32 = `QNAN32;
      else if (&x[30:23])
         fadd32 = x;
      else if (x[30:23] == 8'h00)
         fadd32 = {a[31] & b[31], 31'h00000000};
      else if (y[30:23] == 8'h00)
         fadd32 = x;
      else if (sm == 28'h0)
         fadd32 = 32'h00000000;
      else begin
         if (sm[27]) begin
            sm = sm >> 1;
            e = e + 10'd1;
         end else begin
            for (int i = 0; i < 26; i++) begin
               if (!sm[26]) begin
                  sm = sm << 1;
                  e = e - 10'd1;
               end
            end
         end
         if (e[9] || e == 10'h000)
            fadd32 = {x[31], 31'h00000000};
         else if (e >= 10'h0ff)
            fadd32 = {x[31], 8'hff, 23'h000000};
         else
            fadd32 = {x[31], e[7:0], sm[25:3]};
      end
   endfunction : fadd32

   function automatic logic [63:0] fmul64(input logic [63:0] a,
                                          input logic [63:0] b);
      logic an, bn, ai, bi, az, bz, s;
      logic [105:0] p;
      logic [12:0] e;
      an = (&a[62:52]) && (|a[51:0]);
      bn = (&b[62:52]) && (|b[51:0]);
      ai = (&a[62:52]) && !(|a[51:0]);
      bi = (&b[62:52]) && !(|b[51:0]);
      az = a[62:52] == 11'h000;
      bz = b[62:52] == 11'h000;
      s = a[63] ^ b[63];
      p = {1'b1, a[51:0]} * {1'b1, b[51:0]};
      e = {2'b00, a[62:52]} + {2'b00, b[62:52]} - 13'd1023
          + {12'h000, p[105]};
      if (an)
         fmul64 = a;
      else if (bn)
         fmul64 = b;
      else if ((ai && bz) || (bi && az))
         fmul64 = `CANON_NAN_DBL;
      else if (ai || bi)
         fmul64 = {s, 11'h7ff, 52'h0};
      else if (az || bz || e[12] || e == 13'h0000)
         fmul64 = {s, 63'h0};
      else if (e >= 13'h07ff)
         fmul64 = {s, 11'h7ff, 52'h0};
      else
         fmul64 = {s, e[10:0], p[105] ? p[104:53] : p[103:52]};
   endfunction : fmul64

   // Output scaling and clamping for either width; NaN and infinity pass
   // through the scaler untouched, and a clamped NaN becomes 1.0, or 0 when its sign bit is set.
   function automatic logic [63:0] out_mod(input logic [63:0] v,
                                           input logic dbl,
                                           input logic [1:0] om,
                                           input logic cl);
      logic [11:0] e, emax;
      logic s;
      logic [63:0] r, one;
      e = dbl ? {1'b0, v[62:52]} : {4'h0, v[30:23]};
      emax = dbl ? 12'h7ff : 12'h0ff;
      s = dbl ? v[63] : v[31];
      one = dbl ? `ONE_F64 : `ONE_F32;
      r = v;
      if (e != 12'h000 && e != emax) begin
         unique case (om)
            2'h1: e = e + 12'd1;
            2'h2: e = e + 12'd2;
            2'h3: e = e - 12'd1;
            2'h0: e = e;
         endcase
         if (e == 12'h000)
            r = dbl ? {s, 63'h0} : {32'h0, s, 31'h0};
         else if (e >= emax)
            r = dbl ? {s, 11'h7ff, 52'h0} : {32'h0, s, 8'hff, 23'h0};
         else if (dbl)
            r[62:52] = e[10:0];
         else
            r[30:23] = e[7:0];
      end
      if (cl) begin
         if (s)
            r = 64'h0;
         else if (r >= one)
            r = one;
      end
      out_mod = r;
   endfunction : out_mod

   function automatic logic [31:0] src_mod(input logic [31:0] v,
                                           input logic ab,
                                           input logic ng);
      src_mod = {(v[31] & ~ab) ^ ng, v[30:0]};
   endfunction : src_mod

   ////////////////////////////////////////////////////////////////////////
   // Slot registers and bus slave.

   vmul_pkg::slot_ctrl_t ctrl_ff [4];
   vmul_pkg::slot_src_t src_ff [4];
   logic [31:0] prior_ff [4];
   logic valid_ff;
   logic ack_ff;
   logic [31:0] rdata_ff;
   logic [31:0] nxt_rdata;
   logic wr, issue;
   logic [1:0] sl;
   logic [2:0] fld;

   assign wb_ack_o = ack_ff;
   assign wb_dat_o = rdata_ff;
   assign sl = wb_adr_i[6:5];
   assign fld = wb_adr_i[4:2];
   assign wr = wb_cyc_i && wb_stb_i && wb_we_i && ack_ff;
   assign issue = wr && wb_adr_i == `ADR_ISSUE && wb_sel_i[0]
                  && wb_dat_i[0];

   function automatic logic [31:0] merge(input logic [31:0] o,
                                         input logic [31:0] n,
                                         input logic [3:0] be);
      for (int i = 0; i < 4; i++)
         if (be[i])
            o[i*8 +: 8] = n[i*8 +: 8];
      merge = o;
   endfunction : merge

   always_comb begin
      nxt_rdata = 32'h00000000;
      if (wb_adr_i == `ADR_ISSUE)
         nxt_rdata = {31'h0, valid_ff};
      else if (!wb_adr_i[7] && wb_adr_i[1:0] == 2'b00) begin
         unique case (fld)
            `FLD_CTRL: nxt_rdata = {15'h0, ctrl_ff[sl]};
            `FLD_SRC0: nxt_rdata = src_ff[sl].src0;
            `FLD_SRC1: nxt_rdata = src_ff[sl].src1;
            `FLD_SRC2: nxt_rdata = src_ff[sl].src2;
            `FLD_RESULT: nxt_rdata = prior_ff[sl];
            default: nxt_rdata = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ack_ff <= 1'b0;
         rdata_ff <= 32'h00000000;
      end else begin
         ack_ff <= wb_cyc_i && wb_stb_i && !ack_ff;
         rdata_ff <= nxt_rdata;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         for (int i = 0; i < 4; i++) begin
            ctrl_ff[i] <= `CTRL_RESET;
            src_ff[i] <= {3{`SRC_RESET}};
         end
      end else if (wr && !wb_adr_i[7] && wb_adr_i[1:0] == 2'b00) begin
         unique case (fld)
            `FLD_CTRL: ctrl_ff[sl] <= 17'(merge({15'h0, ctrl_ff[sl]},
                                               wb_dat_i, wb_sel_i));
            `FLD_SRC0: src_ff[sl].src0 <= merge(src_ff[sl].src0,
                                                wb_dat_i, wb_sel_i);
            `FLD_SRC1: src_ff[sl].src1 <= merge(src_ff[sl].src1,
                                                wb_dat_i, wb_sel_i);
            `FLD_SRC2: src_ff[sl].src2 <= merge(src_ff[sl].src2,
                                                wb_dat_i, wb_sel_i);
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Execution of one instruction group across the four vector slots.

   logic [31:0] sa [4], sb [4], sc [4], raw [4], pre [4], res [4];
   logic [7:0] op [4];
   logic bypass [4];
   logic dbl_ok, lit_hit;
   logic [31:0] lit_val;
   logic [63:0] da, db, dres;

   always_comb begin
      for (int s = 0; s < 4; s++) begin
         op[s] = ctrl_ff[s].alu_opcode_field;
         sa[s] = src_mod(src_ff[s].src0, ctrl_ff[s].src_abs[0],
                         ctrl_ff[s].src_neg[0]);
         sb[s] = src_mod(src_ff[s].src1, ctrl_ff[s].src_abs[1],
                         ctrl_ff[s].src_neg[1]);
         sc[s] = src_mod(src_ff[s].src2, ctrl_ff[s].src_abs[2],
                         ctrl_ff[s].src_neg[2]);
         raw[s] = fmul32(sa[s], sb[s], op[s] == `OP_MUL_IEEE);
      end
      dbl_ok = 1'b1;
      for (int s = 0; s < 4; s++)
         dbl_ok = dbl_ok && (op[s] == `OP_MUL64_SCALAR
                             || op[s] == `OP_MUL64_VECTOR);
      // The sign-bearing high words come in through slot 0, so its
      // modifiers stand for the copies held in slots 1 and 2.
      da = {sa[0], src_ff[3].src0};
      db = {sb[0], src_ff[3].src1};
      dres = out_mod(fmul64(da, db), 1'b1, ctrl_ff[0].output_scale_field,
                     ctrl_ff[0].clamp);
      lit_hit = 1'b0;
      lit_val = 32'h00000000;
      for (int s = 0; s < 4; s++) begin
         bypass[s] = 1'b0;
         pre[s] = 32'h00000000;
         unique case (op[s])
            `OP_MUL, `OP_MUL_IEEE: pre[s] = raw[s];
            `OP_DEP_MUL, `OP_DEP_MUL_IEEE: begin
               // Partner product is taken before its output modifiers.
               if (s < 2 && op[s ^ 2] == `OP_MUL)
                  pre[s] = fmul32(sb[s], raw[s ^ 2],
                                  op[s] == `OP_DEP_MUL_IEEE);
               else
                  bypass[s] = 1'b1;
            end
            `OP_MUL_ADD: pre[s] = fadd32(fmul32(sa[s], sb[s], 1'b0),
                                         sc[s]);
            `OP_MUL_ADD_HALF: pre[s] = 32'(out_mod({32'h0,
               fadd32(fmul32(sa[s], sb[s], 1'b0), sc[s])}, 1'b0,
               `SCALE_HALF, 1'b0));
            `OP_MUL_LIGHT: begin
               if (sb[s] == `NEG_MAX_F32 || sb[s] == `NEG_INF_F32
                   || ((&sb[s][30:23]) && (|sb[s][22:0]))
                   || ((&sc[s][30:23]) && (|sc[s][22:0]))
                   || sc[s][31] || sc[s][30:23] == 8'h00)
                  pre[s] = `NEG_MAX_F32;
               else
                  pre[s] = fmul32(sa[s], sb[s], 1'b0);
            end
            `OP_UINT24: begin
               bypass[s] = 1'b1;
               pre[s] = 32'({24'h000000, src_ff[s].src0[23:0]}
                            * {24'h000000, src_ff[s].src1[23:0]});
            end
            `OP_MUL64_SCALAR, `OP_MUL64_VECTOR: begin
               bypass[s] = 1'b1;
               if (dbl_ok)
                  pre[s] = s[0] ? dres[63:32] : dres[31:0];
            end
            default: bypass[s] = 1'b1;
         endcase
         res[s] = bypass[s] ? pre[s] : 32'(out_mod({32'h0, pre[s]}, 1'b0,
                  ctrl_ff[s].output_scale_field, ctrl_ff[s].clamp));
      end
      for (int s = 3; s >= 0; s--) begin
         if (op[s] == `OP_MUL_LIGHT) begin
            lit_hit = 1'b1;
            lit_val = res[s];
         end
      end
      if (lit_hit)
         for (int s = 0; s < 4; s++)
            res[s] = lit_val;
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         for (int i = 0; i < 4; i++)
            prior_ff[i] <= 32'h00000000;
      end else if (issue) begin
         for (int i = 0; i < 4; i++)
            prior_ff[i] <= res[i];
      end
   end

   // A slot write makes the held group stale; an issue in the same cycle
   // cannot coincide because both share the one bus.
   always_ff @(posedge clk_sys) begin
      if (rst)
         valid_ff <= 1'b0;
      else if (issue)
         valid_ff <= 1'b1;
      else if (wr && !wb_adr_i[7])
         valid_ff <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks.

   AST_DBL_PAIRS: assert property (@(posedge clk_sys)
      disable iff (rst)
      issue && dbl_ok |=> prior_ff[0] == prior_ff[2]
      && prior_ff[1] == prior_ff[3])
      else $error("double result pairs differ");

   AST_DBL_NAN: assert property (@(posedge clk_sys) disable iff (rst)
      dbl_ok && ctrl_ff[0].output_scale_field == `SCALE_NONE
      && !ctrl_ff[0].clamp && da[62:52] == 11'h7ff && da[51:0] == 52'h0
      && db[62:52] == 11'h000 && da[63] == 1'b0
      |-> {res[1], res[0]} == `CANON_NAN_DBL)
      else $error("infinity times zero is not the canonical NaN");

   AST_DBL_NAN_SRC0: assert property (@(posedge clk_sys)
      disable iff (rst)
      dbl_ok && !ctrl_ff[0].clamp && (&da[62:52]) && (|da[51:0])
      |-> {res[3], res[2]} == da)
      else $error("first double NaN not propagated");

   AST_U24: assert property (@(posedge clk_sys) disable iff (rst)
      issue && op[2] == `OP_UINT24 && !lit_hit
      && src_ff[2].src0[23:0] == 24'h000002
      |=> prior_ff[2] == {7'h00, $past(src_ff[2].src1[23:0]), 1'b0})
      else $error("narrow product wrong");

   AST_LIGHT_REPL: assert property (@(posedge clk_sys)
      disable iff (rst)
      issue && op[0] == `OP_MUL_LIGHT
      |=> prior_ff[0] == prior_ff[1] && prior_ff[1] == prior_ff[2]
          && prior_ff[2] == prior_ff[3])
      else $error("lighting result not replicated");

   AST_LIGHT_MIN: assert property (@(posedge clk_sys)
      disable iff (rst)
      op[0] == `OP_MUL_LIGHT && sc[0][31] && !ctrl_ff[0].clamp
      && ctrl_ff[0].output_scale_field == `SCALE_NONE
      |-> res[3] == `NEG_MAX_F32)
      else $error("lighting clamp to minimum missing");

   AST_DEP_ILLEGAL: assert property (@(posedge clk_sys)
      disable iff (rst)
      issue && op[3] == `OP_DEP_MUL && op[1] != `OP_MUL_LIGHT
      && op[0] != `OP_MUL_LIGHT && op[2] != `OP_MUL_LIGHT
      |=> prior_ff[3] == 32'h00000000)
      else $error("illegal dependent multiply leaked");

   AST_MUL_ZERO: assert property (@(posedge clk_sys)
      disable iff (rst)
      op[0] == `OP_MUL && sa[0][30:23] == 8'h00 && !lit_hit
      |-> res[0] == 32'h00000000)
      else $error("zero times anything not zero");

   AST_IEEE_ZERO_INF: assert property (@(posedge clk_sys)
      disable iff (rst)
      op[1] == `OP_MUL_IEEE && sa[1][30:23] == 8'h00
      && sb[1][30:0] == 31'h7f800000 |-> &raw[1][30:22])
      else $error("IEEE zero times infinity not NaN");

   AST_ISSUE_VALID: assert property (@(posedge clk_sys)
      disable iff (rst)
      issue |=> valid_ff ##1 (valid_ff || $past(wr)))
      else $error("valid flag not raised by issue");

endmodule : vector_multiply_unit

// [verification/issue_model.sv]
`timescale 1ns/1ps
`include "vmul_regs.svh"

module issue_model (
   input wire logic clk_sys,
   input wire logic wb_ack_o,
   input wire logic [31:0] wb_dat_o,
   output logic wb_cyc_i,
   output logic wb_stb_i,
   output logic wb_we_i,
   output logic [7:0] wb_adr_i,
   output logic [3:0] wb_sel_i,
   output logic [31:0] wb_dat_i
);

   initial begin
      wb_cyc_i = 1'b0;
      wb_stb_i = 1'b0;
      wb_we_i = 1'b0;
      wb_adr_i = 8'h00;
      wb_sel_i = 4'h0;
      wb_dat_i = 32'h00000000;
   end

   ////////////////////////////////////////////////////////////////////////
   // Released lines take the inverse of their last value, so a slave that
   // samples them outside a request cannot pass by luck.
   task automatic xfer(input logic we, input logic [7:0] adr,
                       input logic [31:0] dat, output logic [31:0] rdat);
      @(posedge clk_sys);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_sel_i <= 4'hf;
      wb_dat_i <= dat;
      do @(posedge clk_sys); while (wb_ack_o !== 1'b1);
      rdat = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= ~we;
      wb_adr_i <= ~adr;
      wb_sel_i <= 4'h0;
      wb_dat_i <= ~dat;
   endtask : xfer

   task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
      logic [31:0] d;
      xfer(1'b1, adr, dat, d);
   endtask : wr

   task automatic rd(input logic [7:0] adr, output logic [31:0] dat);
      xfer(1'b0, adr, 32'h00000000, dat);
   endtask : rd

   task automatic slot(input int s, input logic [31:0] c,
                       input logic [31:0] a, b, e);
      logic [7:0] base;
      base = 8'(s * 32);
      wr(base, c);
      wr(base + 8'h04, a);
      wr(base + 8'h08, b);
      wr(base + 8'h0c, e);
   endtask : slot

   // One issue runs the four slots as a group, each with whatever it last received.
   task automatic go();
      wr(`ADR_ISSUE, 32'h00000001);
   endtask : go

endmodule : issue_model

// [verification/tb.sv]
`timescale 1ns/1ps
`include "vmul_regs.svh"

module tb;

   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic wb_cyc_i;
   logic wb_stb_i;
   logic wb_we_i;
   logic [7:0] wb_adr_i;
   logic [3:0] wb_sel_i;
   logic [31:0] wb_dat_i;
   logic [31:0] wb_dat_o;
   logic wb_ack_o;
   int err_total = 0;
   int compares = 0;

   always #5 clk_sys = ~clk_sys;

   vector_multiply_unit i_vector_multiply_unit (.clk_sys(clk_sys),
      .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));

   issue_model issue (.clk_sys(clk_sys), .wb_ack_o(wb_ack_o),
      .wb_dat_o(wb_dat_o), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i));

   ////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] cw(input int op,
                                      input int neg,
                                      input int sc);
      vmul_pkg::slot_ctrl_t c;
      c = '0;
      c.alu_opcode_field = 8'(op);
      c.src_neg = 3'(neg);
      c.output_scale_field = 2'(sc);
      return {15'h0000, c};
   endfunction : cw

   task automatic chk(input string nm, input logic [31:0] exp,
                      input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   task automatic rdchk(input logic [7:0] adr, input string nm,
                        input logic [31:0] exp);
      logic [31:0] d;
      issue.rd(adr, d);
      chk(nm, exp, d);
   endtask : rdchk

   task automatic res(input int s, input string nm, input logic [31:0] exp);
      rdchk(8'(s * 32 + 16), nm, exp);
   endtask : res

   task automatic report_and_stop();
      $display("Counts: compares=%0d err_total=%0d", compares, err_total);
      if (err_total == 0 && compares > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : report_and_stop

   ////////////////////////////////////////////////////////////////////////
   // Slots 1 and 2 carry copies of the slot 0 word; slot 3 holds the low
   // words and its own control word, which must not matter.
   task automatic dbl(input logic [7:0] op, input logic [63:0] a, b,
                      input logic [31:0] c0, c3, input logic [63:0] exp,
                      input string nm);
      for (int s = 0; s < 3; s++) begin
         issue.slot(s, c0 | op, a[63:32], b[63:32], 32'h00000000);
      end
      issue.slot(3, c3 | op, a[31:0], b[31:0], 32'h00000000);
      issue.go();
      for (int s = 0; s < 4; s++) begin
         res(s, nm, s[0] ? exp[63:32] : exp[31:0]);
      end
   endtask : dbl

   task automatic t_regs();
      rdchk(8'h20, "ctrl_reset", 32'h00000000);
      rdchk(`ADR_ISSUE, "valid_reset", 32'h00000000);
      rdchk(8'ha0, "unmapped", 32'h00000000);
      $display("test regs done");
   endtask : t_regs

   task automatic t_dbl();
      dbl(`OP_MUL64_SCALAR, 64'h4008000000000000, 64'h4018000000000000,
          0, 0, 64'h4032000000000000, "dbl_18");
      dbl(`OP_MUL64_VECTOR, 64'h3ff0000000000001, 64'h4000000000000000,
          0, 0, 64'h4000000000000001, "dbl_low");
      dbl(`OP_MUL64_VECTOR, 64'h4008000000000000, 64'h4018000000000000,
          cw(0, 3'b001, 0), cw(0, 3'b010, 2'h1),
          64'hc032000000000000, "dbl_neg");
      dbl(`OP_MUL64_SCALAR, 64'h4008000000000000, 64'h4018000000000000,
          cw(0, 0, `SCALE_HALF), 0, 64'h4022000000000000, "dbl_half");
      dbl(`OP_MUL64_SCALAR, 64'h7ff0000000000000, 64'h0000000000000000,
          0, 0, `CANON_NAN_DBL, "dbl_inf0");
      dbl(`OP_MUL64_SCALAR, 64'h8000000000000001, 64'h3ff0000000000000,
          0, 0, 64'h8000000000000000, "dbl_denorm");
      dbl(`OP_MUL64_VECTOR, 64'h7ff8000000000005, 64'h7ff8000000000009,
          0, 0, 64'h7ff8000000000005, "dbl_nan0");
      dbl(`OP_MUL64_VECTOR, 64'h3ff0000000000000, 64'h7ff8000000000009,
          0, 0, 64'h7ff8000000000009, "dbl_nan1");
      $display("test double done");
   endtask : t_dbl

   task automatic t_single();
      issue.slot(0, cw(`OP_MUL, 0, 0), 32'h00000000, 32'h7f800000, 0);
      issue.slot(1, cw(`OP_MUL_IEEE, 0, 0), 32'h00000000, 32'h7f800000, 0);
      issue.slot(2, cw(`OP_UINT24, 0, 0), 32'hff000002, 32'hab000005, 0);
      issue.slot(3, cw(`OP_UINT24, 0, 0), 32'h00ffffff, 32'h00ffffff, 0);
      issue.go();
      rdchk(`ADR_ISSUE, "valid_set", 32'h00000001);
      issue.wr(8'h10, 32'hffffffff);
      res(0, "mul_zero", 32'h00000000);
      res(1, "ieee_zero_inf", `QNAN32);
      res(2, "u24_small", 32'h0000000a);
      res(3, "u24_max", 32'hfe000001);
      issue.slot(0, cw(`OP_MUL_ADD, 0, 0), 32'h3fc00000, 32'h40000000,
                 32'h3e800000);
      rdchk(`ADR_ISSUE, "valid_clear", 32'h00000000);
      issue.slot(1, cw(`OP_MUL_ADD_HALF, 0, 0), 32'h3fc00000, 32'h40000000,
                 32'h3e800000);
      issue.slot(2, cw(`OP_MUL_ADD, 0, 0), 32'h3f800001, 32'h3f800001,
                 32'hbf800002);
      issue.slot(3, cw(8'h00, 0, 0), 32'h40000000, 32'h40000000, 0);
      issue.go();
      res(0, "multiply_then_add", 32'h40500000);
      res(1, "multiply_then_add_half", 32'h3fd00000);
      res(2, "multiply_then_add_unfused", 32'h00000000);
      $display("test single done");
   endtask : t_single

   // Dependent forms sit only in x and y with a plain multiply partner.
   task automatic t_dep();
      issue.slot(3, cw(`OP_MUL, 0, 2'h1), 32'h40000000, 32'h40400000, 0);
      issue.slot(1, cw(`OP_DEP_MUL, 0, 0), 0, 32'h3f000000, 0);
      issue.slot(2, cw(`OP_MUL, 0, 0), 32'h00000000, 32'h40a00000, 0);
      issue.slot(0, cw(`OP_DEP_MUL_IEEE, 0, 0), 0, 32'h7f800000, 0);
      issue.go();
      res(3, "w_scaled", 32'h41400000);
      res(1, "y_chain", 32'h40400000);
      res(0, "x_chain_ieee", `QNAN32);
      issue.slot(3, cw(`OP_DEP_MUL, 0, 0), 32'h40000000, 32'h40000000, 0);
      issue.slot(0, cw(`OP_MUL, 0, 0), 32'h40000000, 32'h40400000, 0);
      issue.slot(2, cw(`OP_MUL_IEEE, 0, 0), 32'h40800000, 32'h3f800000, 0);
      issue.go();
      res(0, "x_intact", 32'h40c00000);
      res(2, "z_intact", 32'h40800000);
      $display("test dependent done");
   endtask : t_dep

   task automatic t_light();
      logic [31:0] la [7] = '{32'h40000000, 32'h00000000, 32'h40000000,
         32'h40000000, 32'h40000000, 32'h40000000, 32'h40000000};
      logic [31:0] lb [7] = '{32'h40400000, 32'h7f800000, `NEG_MAX_F32,
         `NEG_INF_F32, 32'h7fc00000, 32'h40400000, 32'h40400000};
      logic [31:0] lc [7] = '{32'h3f800000, 32'h3f800000, 32'h3f800000,
         32'h3f800000, 32'h3f800000, 32'h80000000, 32'h7fc00000};
      logic [31:0] le [7] = '{32'h40c00000, 32'h00000000, `NEG_MAX_F32,
         `NEG_MAX_F32, `NEG_MAX_F32, `NEG_MAX_F32, `NEG_MAX_F32};
      for (int s = 1; s < 4; s++) begin
         issue.slot(s, cw(8'h00, 0, 0), 32'h40000000, 32'h40000000, 0);
      end
      for (int i = 0; i < 7; i++) begin
         issue.slot(0, cw(`OP_MUL_LIGHT, 0, 0), la[i], lb[i], lc[i]);
         issue.go();
         for (int s = 0; s < 4; s++) begin
            res(s, "light", le[i]);
         end
      end
      $display("test light done");
   endtask : t_light

   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20) @(posedge clk_sys);
      rst <= 1'b0;
      t_regs();
      t_dbl();
      t_single();
      t_dep();
      t_light();
      report_and_stop();
   end

   // The whole sequence needs about a thousand cycles; this is ample.
   initial begin
      repeat (20000) @(posedge clk_sys);
      err_total++;
      report_and_stop();
   end

endmodule : tb
